// ### rtl/ssb_pkg.sv
package ssb_pkg;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned ADDR_W   = 6;
    localparam int unsigned BITSEL_W = 3;

    // opcode field width, accumulator reset value and data constants
    localparam int unsigned OP_W     = 4;
    localparam logic [7:0]  ACC_RST  = 8'h00;
    localparam logic [7:0]  ALL_ONES = 8'hff;
    localparam logic [7:0]  ONE      = 8'h01;

    // control and status register offsets (byte addresses on the register bus)
    localparam logic [11:0] OFS_CTRL  = 12'h000;
    localparam logic [11:0] OFS_ACC   = 12'h004;
    localparam logic [11:0] OFS_FLAGS = 12'h008;
    localparam logic [11:0] OFS_STAT  = 12'h00c;

    // flag bit positions inside the flags register
    localparam int unsigned FLAG_C  = 0;
    localparam int unsigned FLAG_AUX_CARRY = 1;
    localparam int unsigned FLAG_Z         = 2;
    localparam int unsigned FLAG_OVERFLOW  = 3;

    // skip cost in machine cycles
    localparam int unsigned SKIP_CYCLES   = 2;
    localparam int unsigned NOSKIP_CYCLES = 1;

    typedef enum logic [OP_W-1:0] {
        SSB_OP_NONE,
        SSB_OP_SUB_WITH_BORROW_TO_ACC,
        SSB_OP_SUB_WITH_BORROW_TO_MEM,
        SSB_OP_SUB_MEM_TO_ACC,
        SSB_OP_SUBTRACT_TO_MEM,
        SSB_OP_SUB_IMM_TO_ACC,
        SSB_OP_DEC_SKIP_ZERO_MEM,
        SSB_OP_DEC_SKIP_ZERO_ACC,
        SSB_OP_INC_SKIP_ZERO_MEM,
        SSB_OP_INC_SKIP_ZERO_ACC,
        SSB_OP_SET_BYTE,
        SSB_OP_SET_BIT,
        SSB_OP_SKIP_IF_BIT_ONE,
        SSB_OP_SWAP_NIBBLES,
        SSB_OP_ROTATE_RIGHT_CARRY_TO_ACC
    } ssb_op_t;

    typedef struct packed {
        logic                overflowFlag;
        logic                zeroFlag;
        logic                auxCarryFlag;
        logic                carryFlag;
    } ssb_flags_t;

    typedef struct packed {
        ssb_op_t             op;
        logic [ADDR_W-1:0]   addr;
        logic [BITSEL_W-1:0] bitSel;
        logic [DATA_W-1:0]   imm;
    } ssb_cmd_t;

    typedef struct packed {
        logic                we;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } ssb_mem_wr_t;
endpackage

// ### rtl/ssb_adder.sv
`timescale 1ns/100ps
`default_nettype none
// a + b + cin with carry, half carry and signed overflow
module ssb_adder #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] a,
    input  wire logic [WIDTH-1:0] b,
    input  wire logic             cin,
    output logic      [WIDTH-1:0] sum,
    output logic                  cout,
    output logic                  halfCarry,
    output logic                  overflow
);
    // refused at elaboration: the half carry needs an even split
    if (WIDTH < 8 || WIDTH % 2 != 0) begin
        $error("ssb_adder: WIDTH must be even and at least 8");
    end

    logic [WIDTH:0]   full;
    logic [WIDTH/2:0] low;

    assign full      = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
    assign low       = {1'b0, a[WIDTH/2-1:0]} + {1'b0, b[WIDTH/2-1:0]}
                       + {{(WIDTH/2){1'b0}}, cin};
    assign sum       = full[WIDTH-1:0];
    assign cout      = full[WIDTH];
    assign halfCarry = low[WIDTH/2];
    // operands alike in sign, result of the other sign
    assign overflow  = (a[WIDTH-1] == b[WIDTH-1])
                       && (sum[WIDTH-1] != a[WIDTH-1]);
endmodule
`default_nettype wire

// ### rtl/ssb_datapath.sv
// Notes on behaviour
// - borrow subtract: acc + ~mem + carry to acc or memory, flags updated.
// - plain subtract: acc + ~mem + 1 to acc or memory, flags updated.
// - immediate subtract: acc + ~imm + 1 to acc, flags updated.
// - decrement-skip writes memory minus one back, skips on zero, no flags.
// - acc decrement-skip puts memory minus one in acc, skips on zero.
// - increment-skip writes memory plus one back, skips on zero, no flags.
// - acc increment-skip puts memory plus one in acc, skips on zero.
// - a skip flushes the prefetched instruction and adds one dummy cycle.
// - byte set writes all ones to the addressed byte, flags untouched.
// - bit set forces only the selected bit to one, rest and flags kept.
// - skip-if-bit-one skips on a set bit, memory and flags unchanged.
// - nibble swap exchanges the two halves of the byte and writes it back.
// - rotate-right-carry to acc: old carry to bit 7, bit 0 to carry.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module ssb_datapath #(
    parameter int unsigned DATA_W = ssb_pkg::DATA_W,
    parameter int unsigned ADDR_W = ssb_pkg::ADDR_W
) (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    // instruction issue from the fetch unit
    input  wire logic                   cmdValid,
    input  wire ssb_pkg::ssb_cmd_t      cmd,
    // operand read back from data memory for cmd.addr
    input  wire logic [DATA_W-1:0]      memRdata,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // results
    output ssb_pkg::ssb_mem_wr_t        memWr,
    output logic      [DATA_W-1:0]      acc,
    output ssb_pkg::ssb_flags_t         flags,
    output logic                        skipFlush,
    output logic                        busy
);
    // structs in the package fix the widths, so other values are refused
    if (DATA_W != ssb_pkg::DATA_W || ADDR_W != ssb_pkg::ADDR_W) begin
        $error("ssb_datapath: widths must match the package");
    end

    logic [DATA_W-1:0]   acc_q;
    logic [DATA_W-1:0]   acc_d;
    ssb_pkg::ssb_flags_t flags_q;
    ssb_pkg::ssb_flags_t flags_d;
    ssb_pkg::ssb_mem_wr_t memWr_q;
    ssb_pkg::ssb_mem_wr_t memWr_d;
    logic                skip_d;
    logic                skipFlush_q;
    logic                busy_q;
    logic                haltExec_q;
    logic [7:0]          skipCount_q;
    logic [7:0]          execCount_q;
    logic [31:0]         prdata_q;
    logic                pready_q;
    logic                pslverr_q;

    ssb_pkg::ssb_op_t    op;
    logic                accept;
    logic [DATA_W-1:0]   addB;
    logic                addCin;
    logic [DATA_W-1:0]   addSum;
    logic                addCout;
    logic                addHalf;
    logic                addOv;
    logic [DATA_W-1:0]   bitMask;

    assign op = cmd.op;
    // dummy cycle stalls acceptance of the next instruction
    assign accept = cmdValid && !busy_q && !haltExec_q;

    // subtraction as addition of complement
    always_comb begin
        addB   = ~memRdata;
        addCin = 1'b1;
        case (op)
            ssb_pkg::SSB_OP_SUB_WITH_BORROW_TO_ACC,
            ssb_pkg::SSB_OP_SUB_WITH_BORROW_TO_MEM: begin
                addCin = flags_q.carryFlag;
            end
            ssb_pkg::SSB_OP_SUB_IMM_TO_ACC: begin
                addB = ~cmd.imm;
            end
            default: begin
                addCin = 1'b1;
            end
        endcase
    end

    ssb_adder #(
        .WIDTH (DATA_W)
    ) u_adder (
        .a         (acc_q),
        .b         (addB),
        .cin       (addCin),
        .sum       (addSum),
        .cout      (addCout),
        .halfCarry (addHalf),
        .overflow  (addOv)
    );

    always_comb begin
        bitMask = '0;
        bitMask[cmd.bitSel] = 1'b1;
    end

    always_comb begin
        acc_d         = acc_q;
        flags_d       = flags_q;
        memWr_d       = '0;
        memWr_d.addr  = cmd.addr;
        memWr_d.wdata = memRdata;
        skip_d        = 1'b0;
        if (accept) begin
            case (op)
                ssb_pkg::SSB_OP_SUB_WITH_BORROW_TO_ACC,
                ssb_pkg::SSB_OP_SUB_MEM_TO_ACC,
                ssb_pkg::SSB_OP_SUB_IMM_TO_ACC: begin
                    acc_d = addSum;
                end
                ssb_pkg::SSB_OP_SUB_WITH_BORROW_TO_MEM,
                ssb_pkg::SSB_OP_SUBTRACT_TO_MEM: begin
                    memWr_d.we    = 1'b1;
                    memWr_d.wdata = addSum;
                end
                ssb_pkg::SSB_OP_DEC_SKIP_ZERO_MEM: begin
                    memWr_d.we    = 1'b1;
                    memWr_d.wdata = memRdata - ssb_pkg::ONE;
                    skip_d        = (memRdata == ssb_pkg::ONE);
                end
                ssb_pkg::SSB_OP_DEC_SKIP_ZERO_ACC: begin
                    acc_d  = memRdata - ssb_pkg::ONE;
                    skip_d = (memRdata == ssb_pkg::ONE);
                end
                ssb_pkg::SSB_OP_INC_SKIP_ZERO_MEM: begin
                    memWr_d.we    = 1'b1;
                    memWr_d.wdata = memRdata + ssb_pkg::ONE;
                    skip_d        = (memRdata == ssb_pkg::ALL_ONES);
                end
                ssb_pkg::SSB_OP_INC_SKIP_ZERO_ACC: begin
                    acc_d  = memRdata + ssb_pkg::ONE;
                    skip_d = (memRdata == ssb_pkg::ALL_ONES);
                end
                ssb_pkg::SSB_OP_SET_BYTE: begin
                    memWr_d.we    = 1'b1;
                    memWr_d.wdata = ssb_pkg::ALL_ONES;
                end
                ssb_pkg::SSB_OP_SET_BIT: begin
                    memWr_d.we    = 1'b1;
                    memWr_d.wdata = memRdata | bitMask;
                end
                ssb_pkg::SSB_OP_SKIP_IF_BIT_ONE: begin
                    skip_d = |(memRdata & bitMask);
                end
                ssb_pkg::SSB_OP_SWAP_NIBBLES: begin
                    memWr_d.we    = 1'b1;
                    memWr_d.wdata = {memRdata[3:0], memRdata[7:4]};
                end
                ssb_pkg::SSB_OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
                    acc_d = {flags_q.carryFlag, memRdata[7:1]};
                    flags_d.carryFlag = memRdata[0];
                end
                default: begin
                    acc_d = acc_q;
                end
            endcase
            case (op)
                ssb_pkg::SSB_OP_SUB_WITH_BORROW_TO_ACC,
                ssb_pkg::SSB_OP_SUB_WITH_BORROW_TO_MEM,
                ssb_pkg::SSB_OP_SUB_MEM_TO_ACC,
                ssb_pkg::SSB_OP_SUBTRACT_TO_MEM,
                ssb_pkg::SSB_OP_SUB_IMM_TO_ACC: begin
                    flags_d.zeroFlag     = (addSum == '0);
                    flags_d.carryFlag    = addCout;
                    flags_d.auxCarryFlag = addHalf;
                    flags_d.overflowFlag = addOv;
                end
                default: begin
                    flags_d.zeroFlag = flags_d.zeroFlag;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            acc_q   <= ssb_pkg::ACC_RST;
            flags_q <= '0;
        end else begin
            acc_q   <= acc_d;
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            memWr_q <= '0;
        end else begin
            memWr_q <= memWr_d;
        end
    end

    // skip: flush pulse plus one dummy cycle where no issue is taken
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            skipFlush_q <= 1'b0;
            busy_q      <= 1'b0;
        end else begin
            skipFlush_q <= skip_d;
            busy_q      <= skip_d;
        end
    end

    // counters visible to software, wrap silently
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            skipCount_q <= '0;
            execCount_q <= '0;
        end else begin
            if (skip_d) begin
                skipCount_q <= skipCount_q + 8'h01;
            end
            if (accept) begin
                execCount_q <= execCount_q + 8'h01;
            end
        end
    end

    // APB: zero wait states, unmapped offsets answer with pslverr
    logic apbSetup;
    logic mapped;
    assign apbSetup = psel && !penable;
    assign mapped   = (paddr == ssb_pkg::OFS_CTRL)
                   || (paddr == ssb_pkg::OFS_ACC)
                   || (paddr == ssb_pkg::OFS_FLAGS)
                   || (paddr == ssb_pkg::OFS_STAT);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= apbSetup;
            pslverr_q <= apbSetup && !mapped;
            prdata_q  <= '0;
            if (apbSetup && !pwrite) begin
                case (paddr)
                    ssb_pkg::OFS_CTRL:  prdata_q <= {31'h0, haltExec_q};
                    ssb_pkg::OFS_ACC:   prdata_q <= {24'h0, acc_q};
                    ssb_pkg::OFS_FLAGS: prdata_q <= {28'h0, flags_q};
                    ssb_pkg::OFS_STAT:  prdata_q <= {15'h0, busy_q,
                                                     skipCount_q, execCount_q};
                    default:            prdata_q <= '0;
                endcase
            end
        end
    end

    // software may halt issue; write takes effect in the access phase
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            haltExec_q <= 1'b0;
        end else if (psel && penable && pready_q && pwrite
                     && paddr == ssb_pkg::OFS_CTRL) begin
            haltExec_q <= pwdata[0];
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign memWr     = memWr_q;
    assign acc       = acc_q;
    assign flags     = flags_q;
    assign skipFlush = skipFlush_q;
    assign busy      = busy_q;
endmodule
`default_nettype wire

// ### verification/ssb_data_mem.sv
`timescale 1ns/100ps
`default_nettype none
module ssb_data_mem (
    input  wire logic                 clock,
    input  wire ssb_pkg::ssb_mem_wr_t wr,
    input  wire logic [5:0]           rdAddr,
    output logic      [7:0]           rdata
);
    logic [7:0] store [64];
    // read is combinational: operand must be valid in the issue cycle
    assign rdata = store[rdAddr];
    // plain always: the bench preloads cells directly between edges
    always @(posedge clock) begin
        if (wr.we) begin
            store[wr.addr] <= wr.wdata;
        end
    end
endmodule
`default_nettype wire

// ### verification/ssb_datapath_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ssb_datapath_sva (
    input wire logic                 clock,
    input wire logic                 rst_n,
    input wire logic                 cmdValid,
    input wire ssb_pkg::ssb_cmd_t    cmd,
    input wire logic [7:0]           memRdata,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 pready,
    input wire ssb_pkg::ssb_mem_wr_t memWr,
    input wire logic [7:0]           acc,
    input wire ssb_pkg::ssb_flags_t  flags,
    input wire logic                 skipFlush,
    input wire logic                 busy
);
    logic       haltQ;
    logic       take;
    logic       bitHit;
    logic [8:0] immSum;
    // mirror of the halt bit, so refused commands are not judged
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            haltQ <= 1'b0;
        end else if (psel && penable && pready && pwrite
                     && paddr == ssb_pkg::OFS_CTRL) begin
            haltQ <= pwdata[0];
        end
    end
    assign take   = cmdValid && !busy && !haltQ;
    assign bitHit = memRdata[cmd.bitSel];
    assign immSum = {1'b0, acc} + {1'b0, ~cmd.imm} + 9'h001;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    set_byte_a: assert property (
        take && cmd.op == ssb_pkg::SSB_OP_SET_BYTE
        |=> memWr.we && memWr.wdata == 8'hff && $stable(flags))
        else $error("byte set wrong");
    bit_set_a: assert property (
        take && cmd.op == ssb_pkg::SSB_OP_SET_BIT |=> memWr.we
        && memWr.wdata == ($past(memRdata) | (8'h01 << $past(cmd.bitSel))))
        else $error("bit set wrong");
    bit_skip_a: assert property (
        take && cmd.op == ssb_pkg::SSB_OP_SKIP_IF_BIT_ONE
        |=> !memWr.we && skipFlush == $past(bitHit))
        else $error("bit skip wrong");
    inc_acc_a: assert property (
        take && cmd.op == ssb_pkg::SSB_OP_INC_SKIP_ZERO_ACC
        |=> acc == $past(memRdata) + 8'h01 && !memWr.we && $stable(flags))
        else $error("increment to acc wrong");
    dec_mem_a: assert property (
        take && cmd.op == ssb_pkg::SSB_OP_DEC_SKIP_ZERO_MEM
        |=> memWr.we && memWr.wdata == $past(memRdata) - 8'h01
        && skipFlush == ($past(memRdata) == 8'h01))
        else $error("decrement to memory wrong");
    sub_imm_a: assert property (
        take && cmd.op == ssb_pkg::SSB_OP_SUB_IMM_TO_ACC
        |=> {flags.carryFlag, acc} == $past(immSum))
        else $error("immediate subtract wrong");
    skip_dummy_a: assert property (skipFlush |-> busy ##1 !busy)
        else $error("dummy cycle wrong");
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("bus answer missing");
    cover property (skipFlush);
    cover property (take && cmd.op == ssb_pkg::SSB_OP_SUB_WITH_BORROW_TO_MEM);
    cover property (take
        && cmd.op == ssb_pkg::SSB_OP_ROTATE_RIGHT_CARRY_TO_ACC);
endmodule
`default_nettype wire

// ### verification/ssb_datapath_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ssb_datapath_tb_top;
    logic                 clock, rst_n, cmdValid, psel, penable, pwrite;
    logic                 pready, pslverr, busy, skipFlush, err;
    logic [7:0]           memRdata, acc, expAcc;
    logic [3:0]           expFlags;
    logic [11:0]          paddr, r;
    logic [31:0]          pwdata, prdata, rd;
    int                   errors, comparisons;
    ssb_pkg::ssb_cmd_t    cmd;
    ssb_pkg::ssb_mem_wr_t memWr;
    ssb_pkg::ssb_flags_t  flags;
    ssb_datapath dut (
        .clock(clock), .rst_n(rst_n), .cmdValid(cmdValid), .cmd(cmd),
        .memRdata(memRdata), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .memWr(memWr), .acc(acc),
        .flags(flags), .skipFlush(skipFlush), .busy(busy));
    ssb_data_mem mem (.clock(clock), .wr(memWr), .rdAddr(cmd.addr),
        .rdata(memRdata));
    always #2 clock = ~clock;
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask
    task automatic end_sim();
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic issue(input ssb_pkg::ssb_op_t op, input logic [5:0] a,
        input logic [2:0] b, input logic [7:0] x);
        @(posedge clock);
        while (busy !== 1'b0) @(posedge clock);
        cmdValid <= 1'b1;
        cmd <= '{op: op, addr: a, bitSel: b, imm: x};
        @(posedge clock);
        cmdValid <= 1'b0;
        #1;
    endtask
    task automatic put(input logic [5:0] a, input logic [7:0] v);
        mem.store[a] = v;
    endtask
    function automatic logic [11:0] ref_sub(input logic [7:0] a, b,
        input logic c);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, ~b} + {8'h00, c};
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, c};
        return {(a[7] == ~b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s};
    endfunction
    task automatic sub_test();
        ssb_pkg::ssb_op_t ops [5] = '{ssb_pkg::SSB_OP_SUB_WITH_BORROW_TO_ACC,
            ssb_pkg::SSB_OP_SUB_WITH_BORROW_TO_MEM, ssb_pkg::SSB_OP_SUB_MEM_TO_ACC,
            ssb_pkg::SSB_OP_SUBTRACT_TO_MEM, ssb_pkg::SSB_OP_SUB_IMM_TO_ACC};
        logic [7:0] av [5] = '{8'h50, 8'h30, 8'h80, 8'h7f, 8'h00};
        logic [7:0] bv [5] = '{8'h30, 8'h50, 8'h01, 8'hff, 8'h00};
        foreach (ops[i]) foreach (av[j]) begin
            put(6'h05, av[j] + 8'h01);
            issue(ssb_pkg::SSB_OP_DEC_SKIP_ZERO_ACC, 6'h05, 3'h0, 8'h00);
            put(6'h06, bv[j]);
            r = ref_sub(av[j], bv[j], (i < 2) ? expFlags[0] : 1'b1);
            issue(ops[i], 6'h06, 3'h0, bv[j]);
            check(flags, r[11:8]);
            expAcc = (i == 1 || i == 3) ? av[j] : r[7:0];
            check({memWr.we, acc}, {i == 1 || i == 3, expAcc});
            if (i == 1 || i == 3) check(memWr.wdata, r[7:0]);
            expFlags = r[11:8];
        end
    endtask
    task automatic skip_test();
        ssb_pkg::ssb_op_t ops [8] = '{ssb_pkg::SSB_OP_DEC_SKIP_ZERO_MEM,
            ssb_pkg::SSB_OP_DEC_SKIP_ZERO_ACC, ssb_pkg::SSB_OP_DEC_SKIP_ZERO_MEM,
            ssb_pkg::SSB_OP_DEC_SKIP_ZERO_ACC, ssb_pkg::SSB_OP_INC_SKIP_ZERO_MEM,
            ssb_pkg::SSB_OP_INC_SKIP_ZERO_ACC, ssb_pkg::SSB_OP_INC_SKIP_ZERO_MEM,
            ssb_pkg::SSB_OP_INC_SKIP_ZERO_ACC};
        logic [7:0] mv [8] = '{8'h01, 8'h01, 8'h00, 8'h80, 8'hff, 8'hff, 8'h7f, 8'h00};
        logic [7:0] n;
        foreach (ops[i]) begin
            put(6'h09, mv[i]);
            n = (i < 4) ? mv[i] - 8'h01 : mv[i] + 8'h01;
            issue(ops[i], 6'h09, 3'h0, 8'h00);
            if (i % 2 == 1) expAcc = n;
            check({memWr.we, acc, flags}, {i % 2 == 0, expAcc, expFlags});
            if (i % 2 == 0) check(memWr.wdata, n);
            check({skipFlush, busy}, {2{n == 8'h00}});
            @(posedge clock);
            #1;
            check({skipFlush, busy}, 2'b00);
        end
        // a command offered in the dummy cycle must be dropped
        put(6'h09, 8'h01);
        @(posedge clock);
        cmdValid <= 1'b1;
        cmd <= '{ssb_pkg::SSB_OP_DEC_SKIP_ZERO_MEM, 6'h09, 3'h0, 8'h00};
        @(posedge clock);
        cmd.op <= ssb_pkg::SSB_OP_SET_BYTE;
        @(posedge clock);
        cmdValid <= 1'b0;
        #1;
        check({memWr.we, busy, mem.store[6'h09]}, 10'h000);
    endtask
    task automatic bit_test();
        logic [7:0] pat = 8'ha5;
        put(6'h0c, 8'h00);
        issue(ssb_pkg::SSB_OP_SET_BYTE, 6'h0c, 3'h0, 8'h00);
        check({memWr, flags}, {1'b1, 6'h0c, 8'hff, expFlags});
        for (int i = 0; i < 8; i++) begin
            put(6'h0d, 8'h5a);
            issue(ssb_pkg::SSB_OP_SET_BIT, 6'h0d, i[2:0], 8'h00);
            check({memWr.wdata, flags}, {8'h5a | (8'h01 << i), expFlags});
            put(6'h0e, pat);
            issue(ssb_pkg::SSB_OP_SKIP_IF_BIT_ONE, 6'h0e, i[2:0], 8'h00);
            check({memWr.we, skipFlush, flags}, {1'b0, pat[i], expFlags});
        end
        put(6'h0f, 8'h3c);
        issue(ssb_pkg::SSB_OP_SWAP_NIBBLES, 6'h0f, 3'h0, 8'h00);
        check({memWr.we, memWr.wdata}, {1'b1, 8'hc3});
        for (int i = 0; i < 2; i++) begin
            put(6'h10, i ? 8'h02 : 8'h81);
            issue(ssb_pkg::SSB_OP_ROTATE_RIGHT_CARRY_TO_ACC, 6'h10, 3'h0, 8'h00);
            expAcc = {expFlags[0], i ? 7'h01 : 7'h40};
            expFlags[0] = (i == 0);
            check({memWr.we, acc, flags}, {1'b0, expAcc, expFlags});
        end
    endtask
    task automatic apb_test();
        apb(1'b0, ssb_pkg::OFS_FLAGS, 32'h0);
        check({err, rd}, {1'b0, 28'h0, expFlags});
        apb(1'b1, ssb_pkg::OFS_CTRL, 32'h1);
        put(6'h14, 8'h00);
        issue(ssb_pkg::SSB_OP_SET_BYTE, 6'h14, 3'h0, 8'h00);
        check(memWr.we, 1'b0);
        apb(1'b0, ssb_pkg::OFS_CTRL, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, ssb_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, ssb_pkg::OFS_ACC, 32'h55);
        apb(1'b0, ssb_pkg::OFS_ACC, 32'h0);
        check({err, rd}, {1'b0, 24'h0, expAcc});
        apb(1'b0, 12'h010, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
        issue(ssb_pkg::SSB_OP_SET_BYTE, 6'h14, 3'h0, 8'h00);
        check(memWr.we, 1'b1);
        // 80 commands taken in all, 14 of them skipped, dummy cycle over
        apb(1'b0, ssb_pkg::OFS_STAT, 32'h0);
        check({err, rd}, {1'b0, 16'h0000, 8'h0e, 8'h50});
    endtask
    initial begin
        {clock, rst_n, cmdValid, psel, penable, pwrite} = '0;
        {paddr, pwdata, cmd, errors, comparisons} = '0;
        {expAcc, expFlags} = '0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        check({acc, flags, busy, skipFlush, memWr.we, pready}, '0);
        sub_test();
        skip_test();
        bit_test();
        apb_test();
        end_sim();
    end
    initial begin
        #100000;
        errors++;
        end_sim();
    end
endmodule
bind ssb_datapath ssb_datapath_sva chk (.clock(clock), .rst_n(rst_n),
    .cmdValid(cmdValid), .cmd(cmd), .memRdata(memRdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .memWr(memWr), .acc(acc), .flags(flags),
    .skipFlush(skipFlush), .busy(busy));
`default_nettype wire
